// ### ssb_defines.svh
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH

// Geometry of the wide (x36) organisation
`define SSB_ADDR_W      21
`define SSB_LANES       4
`define SSB_LANE_W      9
`define SSB_DATA_W      36
`define SSB_BEAT_W      2

// Asynchronous pin synchroniser depth
`define SSB_SYNC_DEPTH  3

// Wake-up time after the sleep request falls, in clock cycles
`define SSB_WAKE_CYCLES 2
`define SSB_WAKE_W      2

// Reset values
`define SSB_RST_BEAT    2'h0
`define SSB_RST_WAKE    2'h0
`define SSB_RST_ADDR    21'h000000
`define SSB_RST_DATA    36'h0_0000_0000
`define SSB_RST_LANES   4'h0

`endif

// ### ssb_pkg.sv
`include "ssb_defines.svh"

package ssb_pkg;

  // Gray coded along idle -> read -> write
  typedef enum logic [1:0] {
    SSB_IDLE  = 2'b00,
    SSB_READ  = 2'b01,
    SSB_WRITE = 2'b11
  } ssb_state_e;

  typedef logic [`SSB_ADDR_W-1:0] ssb_addr_t;
  typedef logic [`SSB_DATA_W-1:0] ssb_data_t;
  typedef logic [`SSB_LANES-1:0]  ssb_lane_t;
  typedef logic [`SSB_BEAT_W-1:0] ssb_beat_t;

endpackage

// ### ssb_burst_if.sv
`timescale 1ns/1ps

interface ssb_burst_if;
  import ssb_pkg::*;

  logic      load;
  logic      advance;
  logic      order;
  ssb_beat_t load_bits;
  ssb_beat_t cur_bits;
  ssb_beat_t next_bits;

  modport ctrl (
    output load,
    output advance,
    output order,
    output load_bits,
    input  cur_bits,
    input  next_bits
  );

  modport cnt (
    input  load,
    input  advance,
    input  order,
    input  load_bits,
    output cur_bits,
    output next_bits
  );
endinterface

// ### ssb_burst_addr.sv
`timescale 1ns/1ps
`include "ssb_defines.svh"

module ssb_burst_addr
  import ssb_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // Counter side of the burst carrier
  ssb_burst_if.cnt  bif
);

  ssb_beat_t start_q;
  ssb_beat_t start_d;
  ssb_beat_t count_q;
  ssb_beat_t count_d;
  ssb_beat_t count_nx;

  assign count_nx = count_q + 2'h1;
  assign start_d  = bif.load ? bif.load_bits : start_q;
  assign count_d  = bif.load ? `SSB_RST_BEAT : (bif.advance ? count_nx : count_q);

  // Interleaved XORs the beat count in, linear adds it and wraps at four
  assign bif.cur_bits  = bif.order ? (start_q ^ count_q) : (start_q + count_q);
  assign bif.next_bits = bif.order ? (start_q ^ count_nx) : (start_q + count_nx);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      start_q <= `SSB_RST_BEAT;
      count_q <= `SSB_RST_BEAT;
    end else begin
      start_q <= start_d;
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  interleave_seq_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bif.advance && !bif.load && bif.order |=> (bif.cur_bits ^ start_q) == $past(count_nx))
    else $error("interleaved burst beat wrong");
  linear_seq_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bif.advance && !bif.load && !bif.order |=> bif.cur_bits == ssb_beat_t'($past(bif.cur_bits) + 2'h1))
    else $error("linear burst beat wrong");
  load_start_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bif.load |=> bif.cur_bits == $past(bif.load_bits) ##1 ($past(bif.advance) || bif.cur_bits == start_q))
    else $error("burst did not start at external address bits");

endmodule // ssb_burst_addr

// ### ssb_ctrl.sv
`timescale 1ns/1ps
`include "ssb_defines.svh"

module ssb_ctrl
  import ssb_pkg::*;
(
  // Clock and reset
  input  wire logic      core_clk_i,
  input  wire logic      sys_rst_i,
  // Chip selects and strobes
  input  wire logic      chip_select_one_n_i,
  input  wire logic      chip_select_two_i,
  input  wire logic      chip_select_three_n_i,
  input  wire logic      proc_addr_strobe_n_i,
  input  wire logic      ctrl_addr_strobe_n_i,
  input  wire logic      burst_step_n_i,
  // Write enables
  input  wire logic      all_byte_write_n_i,
  input  wire logic      byte_write_gate_n_i,
  input  wire ssb_lane_t lane_write_n_i,
  // Static and asynchronous controls
  input  wire logic      burst_order_select_i,
  input  wire logic      sleep_request_i,
  input  wire logic      out_enable_n_i,
  // Address and data pins
  input  wire ssb_addr_t addr_i,
  input  wire ssb_data_t dq_i,
  output ssb_data_t      dq_o,
  output logic           dq_oe_o,
  // Storage array port
  output ssb_addr_t      mem_addr_o,
  output logic           mem_rd_o,
  output logic           mem_wr_o,
  output ssb_lane_t      mem_lane_we_o,
  output ssb_data_t      mem_wdata_o,
  input  wire ssb_data_t mem_rdata_i,
  // Status
  output logic           sleeping_o,
  output logic           busy_o
);

  default clocking dflt_cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous pin synchronisers: bit 0 sleep request, bit 1 output enable

  logic [1:0] async_pin;
  logic [1:0] async_s_q;
  logic [1:0] async_s_d;

  assign async_pin = {out_enable_n_i, sleep_request_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [`SSB_SYNC_DEPTH-1:0] chain_q;
      // First stage feeds only the second; a change counts once stages two and three agree
      assign async_s_d[gi] = (chain_q[1] == chain_q[2]) ? chain_q[2] : async_s_q[gi];
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          chain_q <= 3'h0;
        end else begin
          chain_q <= {chain_q[1:0], async_pin[gi]};
        end
      end
    end
  endgenerate

  logic sleep_s;
  logic oe_off_s;
  assign sleep_s  = async_s_q[0];
  assign oe_off_s = async_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up counter

  logic [`SSB_WAKE_W-1:0] wake_q;
  logic [`SSB_WAKE_W-1:0] wake_d;
  logic                   acc_en;

  // Holding the counter loaded while asleep gives the full delay after release
  assign wake_d = sleep_s ? `SSB_WAKE_W'(`SSB_WAKE_CYCLES)
                          : ((wake_q != `SSB_RST_WAKE) ? wake_q - 2'h1 : wake_q);
  assign acc_en = !sleep_s && (wake_q == `SSB_RST_WAKE);

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic      wr_dec;
  ssb_lane_t lane_mask;

  assign wr_dec    = !all_byte_write_n_i || (!byte_write_gate_n_i && !(&lane_write_n_i));
  // Each mask bit covers eight data bits and the lane's parity bit
  assign lane_mask = !all_byte_write_n_i ? {`SSB_LANES{1'b1}}
                   : (!byte_write_gate_n_i ? ~lane_write_n_i : `SSB_RST_LANES);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode

  ssb_state_e state_q;
  ssb_state_e state_d;

  logic cs_ok;
  logic proc_start;
  logic new_cyc;
  logic desel;
  logic begin_rd;
  logic begin_wr;
  logic in_burst;
  logic cont;
  logic step;
  logic rd_go;
  logic wr_go;

  assign cs_ok      = !chip_select_one_n_i && chip_select_two_i && !chip_select_three_n_i;
  // A high first select blocks the processor strobe entirely
  assign proc_start = !chip_select_one_n_i && !proc_addr_strobe_n_i;
  assign new_cyc    = proc_start || !ctrl_addr_strobe_n_i;
  assign desel      = new_cyc && !cs_ok;
  // Lane enables are ignored on a processor strobe edge
  assign begin_rd   = new_cyc && cs_ok && (proc_start || !wr_dec);
  assign begin_wr   = new_cyc && cs_ok && !proc_start && wr_dec;
  assign in_burst   = (state_q != SSB_IDLE);
  assign cont       = !new_cyc && in_burst;
  assign step       = !burst_step_n_i;
  assign rd_go      = acc_en && (begin_rd || (cont && !wr_dec));
  assign wr_go      = acc_en && (begin_wr || (cont && wr_dec));

  always_comb begin
    state_d = state_q;
    if (acc_en) begin
      if (desel) begin
        state_d = SSB_IDLE;
      end else if (rd_go) begin
        state_d = SSB_READ;
      end else if (wr_go) begin
        state_d = SSB_WRITE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst address

  ssb_burst_if bif ();

  ssb_burst_addr u_burst (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .bif        (bif)
  );

  logic [`SSB_ADDR_W-1:2] base_q;
  logic [`SSB_ADDR_W-1:2] base_d;
  ssb_addr_t              tgt_addr;

  assign bif.load      = acc_en && (begin_rd || begin_wr);
  assign bif.advance   = acc_en && cont && step;
  // The order pin is static, so it is sampled directly
  assign bif.order     = burst_order_select_i;
  assign bif.load_bits = addr_i[1:0];
  assign base_d        = bif.load ? addr_i[`SSB_ADDR_W-1:2] : base_q;
  assign tgt_addr      = bif.load ? addr_i
                       : (step ? {base_q, bif.next_bits} : {base_q, bif.cur_bits});

  ////////////////////////////////////////////////////////////////////////////
  // Array access and output pipeline

  logic      mem_rd_q;
  logic      mem_wr_q;
  ssb_addr_t mem_addr_q;
  ssb_lane_t mem_lane_q;
  ssb_data_t mem_wdata_q;
  ssb_data_t dout_q;
  logic      drive_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q   <= SSB_IDLE;
      async_s_q <= 2'h0;
      wake_q    <= `SSB_RST_WAKE;
      base_q    <= (`SSB_ADDR_W-2)'(`SSB_RST_ADDR >> 2);
    end else begin
      state_q   <= state_d;
      async_s_q <= async_s_d;
      wake_q    <= wake_d;
      base_q    <= base_d;
    end
  end

  // Inputs are taken only on the rising edge; address, lanes and data held while asleep, read and write strobes cleared
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= `SSB_RST_ADDR;
      mem_lane_q  <= `SSB_RST_LANES;
      mem_wdata_q <= `SSB_RST_DATA;
    end else begin
      mem_rd_q <= rd_go;
      mem_wr_q <= wr_go;
      if (rd_go || wr_go) begin
        mem_addr_q <= tgt_addr;
      end
      if (wr_go) begin
        mem_lane_q  <= lane_mask;
        mem_wdata_q <= dq_i;
      end
    end
  end

  // Read data lands one edge after the array access; a write clears the drive at once
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dout_q  <= `SSB_RST_DATA;
      drive_q <= 1'b0;
    end else begin
      drive_q <= mem_rd_q && !wr_go;
      if (mem_rd_q) begin
        dout_q <= mem_rdata_i;
      end
    end
  end

  // Final gate by the asynchronous pins
  assign dq_oe_o       = drive_q && !sleep_s && !oe_off_s;
  assign dq_o          = dout_q;
  assign mem_rd_o      = mem_rd_q;
  assign mem_wr_o      = mem_wr_q;
  assign mem_addr_o    = mem_addr_q;
  assign mem_lane_we_o = mem_lane_q;
  assign mem_wdata_o   = mem_wdata_q;
  assign sleeping_o    = sleep_s;
  assign busy_o        = in_burst;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  desel_idle_a: assert property (acc_en && desel |=> !mem_rd_o && !mem_wr_o && state_q == SSB_IDLE)
    else $error("deselect started an access");
  begin_read_a: assert property (acc_en && cs_ok && proc_start |=> mem_rd_o && mem_addr_o == $past(addr_i))
    else $error("processor strobe did not begin read at external address");
  begin_write_a: assert property (acc_en && begin_wr |=> mem_wr_o && mem_addr_o == $past(addr_i)
    && mem_lane_we_o == $past(lane_mask) && mem_wdata_o == $past(dq_i))
    else $error("controller strobe write wrong");
  cont_read_a: assert property (acc_en && cont && step && !wr_dec
    |=> mem_rd_o && mem_addr_o[1:0] == $past(bif.next_bits))
    else $error("burst read did not advance");
  cont_write_a: assert property (acc_en && cont && step && wr_dec |=> mem_wr_o && mem_addr_o[1:0] == $past(bif.next_bits))
    else $error("burst write did not advance");
  hold_addr_a: assert property (acc_en && cont && !step |=> mem_addr_o == $past({base_q, bif.cur_bits}))
    else $error("suspended burst moved address");
  lane_decode_a: assert property (all_byte_write_n_i && (!byte_write_gate_n_i ? &lane_write_n_i : 1'b1)
    |-> !wr_dec && lane_mask == `SSB_RST_LANES)
    else $error("read decoded as write");
  write_hiz_a: assert property (wr_go |=> !dq_oe_o)
    else $error("outputs driven during write");
  sleep_hiz_a: assert property (sleep_s |-> !dq_oe_o && !bif.load)
    else $error("drive or access during sleep");
  oe_gate_a: assert property (oe_off_s || !drive_q |-> !dq_oe_o)
    else $error("outputs driven without enable");
  wake_delay_a: assert property ($fell(sleep_s) |-> !acc_en [*2] ##1 acc_en)
    else $error("wake-up time not two cycles");

  rd_burst_c: cover property (begin_rd && acc_en ##1 (cont && step && !wr_dec) [*3]);
  wr_burst_c: cover property (begin_wr && acc_en ##1 (cont && step && wr_dec) [*3]);
  suspend_c:  cover property (rd_go ##1 (cont && !step && acc_en) ##1 dq_oe_o);
  sleep_c:    cover property (sleep_s ##1 !sleep_s [*3] ##1 rd_go);

endmodule // ssb_ctrl

// ### ssb_array_model.sv
`timescale 1ns/1ps
`include "ssb_defines.svh"

module ssb_array_model
  import ssb_pkg::*;
(
  // Clock
  input  wire logic      core_clk_i,
  // Array port
  input  wire ssb_addr_t mem_addr_i,
  input  wire logic      mem_rd_i,
  input  wire logic      mem_wr_i,
  input  wire ssb_lane_t mem_lane_we_i,
  input  wire ssb_data_t mem_wdata_i,
  output ssb_data_t      mem_rdata_o
);
  // Sixteen cells are enough to tell the bursts of the bench apart
  ssb_data_t cells [16];
  wire [3:0] idx = mem_addr_i[3:0];

  initial begin
    for (int i = 0; i < 16; i++) cells[i] = {9{i[3:0]}};
  end

  // Outside a read the data is inverted, so a late sample never matches
  assign mem_rdata_o = mem_rd_i ? cells[idx] : ~cells[idx];

  always @(posedge core_clk_i) begin
    for (int j = 0; j < `SSB_LANES; j++) begin
      if (mem_wr_i && mem_lane_we_i[j]) cells[idx][`SSB_LANE_W*j +: `SSB_LANE_W] <= mem_wdata_i[`SSB_LANE_W*j +: `SSB_LANE_W];
    end
  end
endmodule // ssb_array_model

// ### testbench.sv
`timescale 1ns/1ps
`include "ssb_defines.svh"
`define SSB_CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module testbench
  import ssb_pkg::*;
;
  typedef struct packed {logic rd; logic wr; logic oe; logic bsy; ssb_addr_t a; ssb_lane_t ln; ssb_data_t d;} ssb_exp_s;

  logic      core_clk_i = 1'b0;
  logic      sys_rst_i = 1'b1;
  logic      chip_select_one_n_i = 1'b1;
  logic      chip_select_two_i = 1'b0;
  logic      chip_select_three_n_i = 1'b1;
  logic      proc_addr_strobe_n_i = 1'b1;
  logic      ctrl_addr_strobe_n_i = 1'b1;
  logic      burst_step_n_i = 1'b1;
  logic      all_byte_write_n_i = 1'b1;
  logic      byte_write_gate_n_i = 1'b1;
  ssb_lane_t lane_write_n_i = 4'hf;
  logic      burst_order_select_i = 1'b0;
  logic      sleep_request_i = 1'b0;
  logic      out_enable_n_i = 1'b1;
  ssb_addr_t addr_i = 21'h000000;
  ssb_data_t dq_i = 36'h0_0000_0000;
  ssb_data_t dq_o, mem_wdata_o, mem_rdata_i;
  ssb_addr_t mem_addr_o;
  ssb_lane_t mem_lane_we_o;
  logic      dq_oe_o, mem_rd_o, mem_wr_o, sleeping_o, busy_o;
  int        err_count = 0;
  int        compares = 0;
  logic      mute = 1'b1;
  logic      asleep = 1'b0;
  logic      bst = 1'b0;
  ssb_addr_t base = 21'h000000;
  ssb_beat_t beat = 2'h0;
  ssb_data_t shadow [16];
  ssb_exp_s  h0, h1;

  always #12.5 core_clk_i = ~core_clk_i;

  ssb_ctrl ssb_ctrl_i (.*);

  ssb_array_model ssb_array_model_i (
    .core_clk_i    (core_clk_i),
    .mem_addr_i    (mem_addr_o),
    .mem_rd_i      (mem_rd_o),
    .mem_wr_i      (mem_wr_o),
    .mem_lane_we_i (mem_lane_we_o),
    .mem_wdata_i   (mem_wdata_o),
    .mem_rdata_o   (mem_rdata_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One command a cycle; the expected effect goes into the pipeline
  task automatic drive(input logic [2:0] cs, input logic ps, cc, st, gw, bw, input ssb_lane_t ln,
                       input ssb_addr_t a, input ssb_data_t d);
    logic     wd;
    logic     go;
    ssb_exp_s e;
    @(negedge core_clk_i);
    #1;
    {chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i} = cs;
    proc_addr_strobe_n_i = ps;
    ctrl_addr_strobe_n_i = cc;
    burst_step_n_i = st;
    all_byte_write_n_i = gw;
    byte_write_gate_n_i = bw;
    lane_write_n_i = ln;
    addr_i = a;
    dq_i = d;
    e = '0;
    wd = !gw || (!bw && ln != 4'hf);
    go = (!cs[2] && !ps) || !cc;
    if (!asleep && go && cs != 3'h2) bst = 1'b0;
    else if (!asleep && (go || bst)) begin
      if (go) begin
        base = a;
        beat = 2'h0;
        bst = 1'b1;
        wd = wd && ps;
      end
      else if (!st) beat++;
      e.rd = !wd;
      e.wr = wd;
      e.a = {base[20:2], burst_order_select_i ? base[1:0] ^ beat : base[1:0] + beat};
      e.ln = gw ? ~ln : 4'hf;
      e.oe = !wd && !out_enable_n_i && !sleep_request_i;
      e.d = wd ? d : shadow[e.a[3:0]];
      for (int j = 0; j < `SSB_LANES; j++) begin
        if (wd && e.ln[j]) shadow[e.a[3:0]][`SSB_LANE_W*j +: `SSB_LANE_W] = d[`SSB_LANE_W*j +: `SSB_LANE_W];
      end
    end
    e.bsy = bst;
    h0 = e;
  endtask

  task automatic idle;
    drive(3'h6, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 21'h000000, 36'h0_0000_0000);
  endtask

  task automatic hold;
    drive(3'h2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 21'h000000, 36'h0_0000_0000);
  endtask

  task automatic cont(input logic st, gw, bw, input ssb_lane_t ln, input ssb_data_t d);
    drive(3'h2, 1'b1, 1'b1, st, gw, bw, ln, 21'h1ffffc, d);
  endtask

  // Processor strobe read with all-byte write low, or a controller strobe read
  task automatic start_r(input logic p, input ssb_addr_t a);
    drive(3'h2, !p, p, 1'b1, !p, 1'b1, 4'h0, a, 36'h0_0000_0000);
  endtask

  task automatic start_w(input ssb_addr_t a, input logic gw, input ssb_lane_t ln, input ssb_data_t d);
    drive(3'h2, 1'b1, 1'b0, 1'b1, gw, 1'b0, ln, a, d);
  endtask

  // The output enable is synchronised, so checks pause while it travels
  task automatic set_oe(input logic oen);
    mute = 1'b1;
    out_enable_n_i = oen;
    repeat (6) idle();
    mute = 1'b0;
  endtask

  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (sleeping_o !== lvl) begin
      hold();
      n++;
      if (n > 20) begin
        err_count++;
        test_done();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk_i) begin
    if (!mute) begin
      `SSB_CHK("busy", h0.bsy, busy_o)
      `SSB_CHK("mem_rd", h0.rd, mem_rd_o)
      `SSB_CHK("mem_wr", h0.wr, mem_wr_o)
      if (h0.rd || h0.wr) `SSB_CHK("mem_addr", h0.a, mem_addr_o)
      if (h0.wr) `SSB_CHK("lanes", h0.ln, mem_lane_we_o)
      if (h0.wr) `SSB_CHK("wdata", h0.d, mem_wdata_o)
      `SSB_CHK("dq_oe", h1.oe, dq_oe_o)
      if (h1.oe) `SSB_CHK("dq", h1.d, dq_o)
    end
    h1 = h0;
    h0 = '0;
  end

  initial begin
    h0 = '0;
    h1 = '0;
    for (int i = 0; i < 16; i++) shadow[i] = {9{i[3:0]}};
    repeat (16) idle();
    sys_rst_i = 1'b0;
    repeat (4) idle();
    mute = 1'b0;
    // All-lane write burst from beat 2, wrapping, with a suspend
    start_w(21'h000006, 1'b0, 4'hf, 36'h1_2345_6789);
    cont(1'b0, 1'b0, 1'b1, 4'hf, 36'h2_2222_2222);
    cont(1'b1, 1'b0, 1'b1, 4'hf, 36'h3_3333_3333);
    drive(3'h6, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'hf, 21'h000001, 36'h4_4444_4444);
    cont(1'b0, 1'b0, 1'b1, 4'hf, 36'h5_5555_5555);
    // Byte lanes, then both read rows of the write decode
    start_w(21'h00000b, 1'b1, 4'he, 36'ha_aaaa_aaaa);
    cont(1'b0, 1'b1, 1'b0, 4'h3, 36'hb_bbbb_bbbb);
    cont(1'b0, 1'b1, 1'b0, 4'hf, 36'hc_cccc_cccc);
    cont(1'b0, 1'b1, 1'b1, 4'h0, 36'hd_dddd_dddd);
    drive(3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 21'h000001, 36'h0_0000_0000);
    drive(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 21'h000001, 36'h0_0000_0000);
    cont(1'b0, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
    set_oe(1'b0);
    // Every start and both orders, suspend and wrap past four beats
    for (int i = 0; i < 8; i++) begin
      burst_order_select_i = i[0];
      start_r(i[2], 21'(i + 4));
      repeat (3) cont(1'b0, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
      cont(1'b1, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
      cont(1'b0, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
      idle();
    end
    // Sleep in mid-burst: drivers off, commands refused, burst resumes
    start_r(1'b1, 21'h00000d);
    mute = 1'b1;
    asleep = 1'b1;
    sleep_request_i = 1'b1;
    wait_sleep(1'b1);
    repeat (3) hold();
    mute = 1'b0;
    repeat (3) cont(1'b0, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
    mute = 1'b1;
    asleep = 1'b0;
    sleep_request_i = 1'b0;
    wait_sleep(1'b0);
    repeat (5) hold();
    mute = 1'b0;
    repeat (3) cont(1'b0, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
    idle();
    // Output enable high during reads, then a write straight after a read
    set_oe(1'b1);
    start_r(1'b0, 21'h000006);
    cont(1'b0, 1'b1, 1'b1, 4'hf, 36'h0_0000_0000);
    start_w(21'h000007, 1'b1, 4'h5, 36'h9_8765_4321);
    idle();
    set_oe(1'b0);
    start_r(1'b1, 21'h000007);
    idle();
    repeat (3) idle();
    test_done();
  end
endmodule // testbench
